// *** sbc_ctrl_map.vh ***
// register map and timing constants for the hardware and watchdog control bank
// assumes a 100 MHz clock and a 16-bit spi frame already deserialised upstream
`ifndef SBC_CTRL_MAP_VH
`define SBC_CTRL_MAP_VH
`define SBC_ADDR_HARDWARE_CONTROL     7'h02
`define SBC_ADDR_WATCHDOG_CONTROL     7'h03
`define SBC_HW_RST_VAL       8'h00
`define SBC_WD_RST_VAL       8'h14
`define SBC_HW_RESTART_CLR   8'hDF
`define SBC_WD_RESTART_KEEP  8'h98
`define SBC_WD_RESTART_SET   8'h04
`define SBC_HW_FSI_DIS       7
`define SBC_HW_TLAG          6
`define SBC_HW_FO_FORCE      5
`define SBC_HW_BUCK_MODE_BY_WAKE_PIN     4
`define SBC_HW_PWM_AUTO      3
`define SBC_HW_BOOST_V       2
`define SBC_HW_BOOST_EN      1
`define SBC_HW_FO_TIMING     0
`define SBC_WD_STM_OFF       6
`define SBC_WATCHDOG_WINDOW_SELECT           5
`define SBC_WD_BUS_WAKE      4
`define SBC_WD_MAX3          3
`define SBC_CLK_MHZ          100
`define SBC_TLAG_SHORT_US    100
`define SBC_TLAG_LONG_US     1000
`define SBC_TLAG_SHORT_CYC   (`SBC_TLAG_SHORT_US * `SBC_CLK_MHZ)
`define SBC_TLAG_LONG_CYC    (`SBC_TLAG_LONG_US * `SBC_CLK_MHZ)
`define SBC_WD_P0_MS         10
`define SBC_WD_P1_MS         20
`define SBC_WD_P2_MS         50
`define SBC_WD_P3_MS         100
`define SBC_WD_P4_MS         200
`define SBC_WD_P5_MS         500
`define SBC_WD_P6_MS         1000
`endif

// *** sbc_ctrl.v ***
// hardware control and watchdog control registers with decoded outputs
// assumes spi frame arrives as a strobe with the 16-bit word, same clock;
// wake pin and config pin are asynchronous and synchronised here
`timescale 1ns/1ps
`include "sbc_ctrl_map.vh"
module sbc_ctrl (
  input  wire        clock,
  input  wire        rst,
  input  wire        soft_reset,
  input  wire        restart,
  input  wire        frame_valid,
  input  wire [15:0] frame_data,
  output reg  [7:0]  read_data,
  output wire        spi_fail_set,
  input  wire        stop_mode,
  input  wire        stop_cmd_written,
  input  wire        wake_pin,
  input  wire        cfg_pin,
  input  wire        large_load,
  input  wire        failure_event,
  input  wire        wd_fail_event,
  input  wire        hw_wd_stm_off_set,
  input  wire        hw_wd_bus_wake_set,
  input  wire        hw_period_load,
  input  wire [2:0]  hw_period_value,
  output reg  [7:0]  hardware_control_q,
  output reg  [7:0]  watchdog_control_q,
  output reg         failsafe_input_enable,
  output reg         second_fail_output_mode,
  output reg         fail_outputs,
  output reg         buck_pwm,
  output reg         boost_enable,
  output reg         boost_low_voltage,
  output reg         failsafe_vcc_off,
  output reg         watchdog_active,
  output reg         watchdog_window_mode,
  output reg         watchdog_reset,
  output reg  [31:0] watchdog_period_cycles,
  output reg         watchdog_period_reserved,
  input  wire        bus_wake
);
  localparam ST_PFM  = 3'b001;
  localparam ST_PWM  = 3'b010;
  localparam ST_LAG  = 3'b100;
  localparam [31:0] LAG_SHORT = `SBC_TLAG_SHORT_CYC;
  localparam [31:0] LAG_LONG  = `SBC_TLAG_LONG_CYC;
  localparam [31:0] CYC_PER_MS = 32'd1000 * `SBC_CLK_MHZ;

  reg  [1:0]  wake_sync_q;
  reg  [1:0]  cfg_sync_q;
  reg         cfg_q;
  reg  [2:0]  buck_st_q;
  reg  [2:0]  buck_st_d;
  reg  [31:0] lag_cnt_q;
  reg  [1:0]  fail_cnt_q;
  reg  [1:0]  rst_cnt_q;
  reg         wd_started_q;
  wire [6:0]  frame_addr  = frame_data[6:0];
  wire        frame_write = frame_data[7];
  wire [7:0]  frame_byte  = frame_data[15:8];
  wire        wake_level  = wake_sync_q[1];
  wire        wr_hw  = frame_valid & frame_write & (frame_addr == `SBC_ADDR_HARDWARE_CONTROL);
  wire        wr_wd  = frame_valid & frame_write & (frame_addr == `SBC_ADDR_WATCHDOG_CONTROL);
  wire        wd_odd = ^frame_byte;

  assign spi_fail_set = wr_wd & wd_odd;

  // pins are asynchronous: two flops before use
  always @(posedge clock) begin
    if (rst) begin
      wake_sync_q <= 2'b00;
      cfg_sync_q  <= 2'b00;
    end else begin
      wake_sync_q <= {wake_sync_q[0], wake_pin};
      cfg_sync_q  <= {cfg_sync_q[0], cfg_pin};
    end
  end

  // config level latched on each soft reset or restart, like a strap
  always @(posedge clock) begin
    if (rst)
      cfg_q <= 1'b0;
    else if (soft_reset | restart)
      cfg_q <= cfg_sync_q[1];
  end

  always @(posedge clock) begin
    if (rst | soft_reset) begin
      hardware_control_q <= `SBC_HW_RST_VAL;
    end else if (restart) begin
      hardware_control_q <= hardware_control_q & `SBC_HW_RESTART_CLR;
    end else if (wr_hw) begin
      hardware_control_q <= frame_byte;
    end
  end

  always @(posedge clock) begin
    if (rst | soft_reset) begin
      watchdog_control_q <= `SBC_WD_RST_VAL;
    end else if (restart) begin
      watchdog_control_q <= (watchdog_control_q & `SBC_WD_RESTART_KEEP)
                            | `SBC_WD_RESTART_SET;
    end else if (wr_wd & ~wd_odd) begin
      watchdog_control_q <= frame_byte;
    end else begin
      // hardware may update rwh fields
      if (hw_wd_stm_off_set)
        watchdog_control_q[`SBC_WD_STM_OFF] <= 1'b1;
      if (hw_wd_bus_wake_set)
        watchdog_control_q[`SBC_WD_BUS_WAKE] <= 1'b1;
      if (hw_period_load)
        watchdog_control_q[2:0] <= hw_period_value;
    end
  end

  // read data returned for any frame to a known address
  always @(posedge clock) begin
    if (rst)
      read_data <= 8'h00;
    else if (frame_valid) begin
      case (frame_addr)
        `SBC_ADDR_HARDWARE_CONTROL: read_data <= hardware_control_q;
        `SBC_ADDR_WATCHDOG_CONTROL: read_data <= watchdog_control_q;
        default:           read_data <= 8'h00;
      endcase
    end
  end

  // buck mode sequencer; lag delays only the pwm to pfm step
  always @* begin
    buck_st_d = buck_st_q;
    case (buck_st_q)
      ST_PFM: begin
        if (!stop_mode)
          buck_st_d = ST_PWM;
        else if (hardware_control_q[`SBC_HW_BUCK_MODE_BY_WAKE_PIN] & wake_level)
          buck_st_d = ST_PWM;
        else if (hardware_control_q[`SBC_HW_PWM_AUTO] & large_load)
          buck_st_d = ST_PWM;
      end
      ST_PWM: begin
        if (stop_mode) begin
          if (hardware_control_q[`SBC_HW_BUCK_MODE_BY_WAKE_PIN]) begin
            if (!wake_level)
              buck_st_d = ST_LAG;
          end else if (hardware_control_q[`SBC_HW_PWM_AUTO]) begin
            if (stop_cmd_written)
              buck_st_d = ST_LAG;
          end else
            buck_st_d = ST_LAG;
        end
      end
      ST_LAG: begin
        if (!stop_mode)
          buck_st_d = ST_PWM;
        else if (hardware_control_q[`SBC_HW_BUCK_MODE_BY_WAKE_PIN] & wake_level)
          buck_st_d = ST_PWM;
        else if (lag_cnt_q == 32'd1)
          buck_st_d = ST_PFM;
      end
      default: buck_st_d = ST_PFM;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      buck_st_q <= ST_PWM;
      lag_cnt_q <= 32'd0;
    end else begin
      buck_st_q <= buck_st_d;
      if (buck_st_d == ST_LAG && buck_st_q != ST_LAG)
        lag_cnt_q <= hardware_control_q[`SBC_HW_TLAG] ? LAG_LONG : LAG_SHORT;
      else if (lag_cnt_q != 32'd0)
        lag_cnt_q <= lag_cnt_q - 32'd1;
    end
  end

  // watchdog failure counting for fail outputs and reset limit
  always @(posedge clock) begin
    if (rst | soft_reset) begin
      fail_cnt_q <= 2'd0;
      rst_cnt_q  <= 2'd0;
    end else if (wd_fail_event) begin
      if (fail_cnt_q != 2'd2)
        fail_cnt_q <= fail_cnt_q + 2'd1;
      if (rst_cnt_q != 2'd3)
        rst_cnt_q <= rst_cnt_q + 2'd1;
    end
  end

  // watchdog started by a bus wake in stop mode
  always @(posedge clock) begin
    if (rst | soft_reset)
      wd_started_q <= 1'b0;
    else if (!stop_mode)
      wd_started_q <= 1'b0;
    else if (bus_wake & watchdog_control_q[`SBC_WD_BUS_WAKE])
      wd_started_q <= 1'b1;
  end

  // registered outputs
  always @(posedge clock) begin
    if (rst) begin
      failsafe_input_enable   <= 1'b1;
      second_fail_output_mode <= 1'b0;
      fail_outputs            <= 1'b0;
      buck_pwm                <= 1'b1;
      boost_enable            <= 1'b0;
      boost_low_voltage       <= 1'b0;
      failsafe_vcc_off        <= 1'b0;
      watchdog_active         <= 1'b1;
      watchdog_window_mode    <= 1'b0;
      watchdog_reset          <= 1'b0;
      watchdog_period_cycles  <= 32'd0;
      watchdog_period_reserved <= 1'b0;
    end else begin
      failsafe_input_enable   <= ~hardware_control_q[`SBC_HW_FSI_DIS];
      second_fail_output_mode <= hardware_control_q[`SBC_HW_FSI_DIS];
      fail_outputs <= hardware_control_q[`SBC_HW_FO_FORCE] | failure_event
                      | (hardware_control_q[`SBC_HW_FO_TIMING] ? (fail_cnt_q != 2'd0)
                         : (fail_cnt_q == 2'd2));
      buck_pwm          <= (buck_st_q != ST_PFM);
      boost_enable      <= hardware_control_q[`SBC_HW_BOOST_EN];
      boost_low_voltage <= hardware_control_q[`SBC_HW_BOOST_V];
      failsafe_vcc_off  <= cfg_q & (fail_cnt_q != 2'd0);
      watchdog_active   <= ~stop_mode | ~watchdog_control_q[`SBC_WD_STM_OFF]
                           | wd_started_q;
      watchdog_window_mode <= watchdog_control_q[`SBC_WATCHDOG_WINDOW_SELECT] & ~wd_started_q;
      watchdog_reset <= wd_fail_event &
                        ~(watchdog_control_q[`SBC_WD_MAX3] & (rst_cnt_q == 2'd3));
      watchdog_period_reserved <= (watchdog_control_q[2:0] == 3'b111);
      case (watchdog_control_q[2:0])
        3'b000:  watchdog_period_cycles <= CYC_PER_MS * `SBC_WD_P0_MS;
        3'b001:  watchdog_period_cycles <= CYC_PER_MS * `SBC_WD_P1_MS;
        3'b010:  watchdog_period_cycles <= CYC_PER_MS * `SBC_WD_P2_MS;
        3'b011:  watchdog_period_cycles <= CYC_PER_MS * `SBC_WD_P3_MS;
        3'b100:  watchdog_period_cycles <= CYC_PER_MS * `SBC_WD_P4_MS;
        3'b101:  watchdog_period_cycles <= CYC_PER_MS * `SBC_WD_P5_MS;
        3'b110:  watchdog_period_cycles <= CYC_PER_MS * `SBC_WD_P6_MS;
        default: watchdog_period_cycles <= 32'd0;
      endcase
    end
  end
endmodule

// *** sbc_ctrl_properties.sv ***
// assertions on the control bank ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module sbc_ctrl_properties (
  input logic        clock,
  input logic        rst,
  input logic        soft_reset,
  input logic        restart,
  input logic        frame_valid,
  input logic [15:0] frame_data,
  input logic [7:0]  read_data,
  input logic        spi_fail_set,
  input logic [7:0]  hardware_control_q,
  input logic [7:0]  watchdog_control_q,
  input logic        failsafe_input_enable,
  input logic        fail_outputs,
  input logic        boost_enable,
  input logic        watchdog_period_reserved
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wr(a);
    frame_valid && frame_data[7] && frame_data[6:0] == a;
  endsequence
  sequence s_odd;
    s_wr(7'h03) ##0 ^frame_data[15:8];
  endsequence
  property p_odd; s_odd |-> spi_fail_set; endproperty
  a_odd: assert property (p_odd) else $error("odd write not flagged");
  // only rw bits, hardware may move the rwh ones meanwhile
  property p_drop; s_odd ##0 !(soft_reset || restart)
    |=> (watchdog_control_q & 8'hA8) == ($past(watchdog_control_q) & 8'hA8); endproperty
  a_drop: assert property (p_drop) else $error("odd write taken");
  property p_hw_wr; s_wr(7'h02) ##0 !(soft_reset || restart)
    |=> hardware_control_q == $past(frame_data[15:8]); endproperty
  a_hw_wr: assert property (p_hw_wr) else $error("write lost");
  property p_rd; frame_valid && !frame_data[7] && frame_data[6:0] == 7'h02
    |=> read_data == $past(hardware_control_q); endproperty
  a_rd: assert property (p_rd) else $error("bad read data");
  property p_soft; soft_reset
    |=> hardware_control_q == 8'h00 && watchdog_control_q == 8'h14; endproperty
  a_soft: assert property (p_soft) else $error("bad soft reset value");
  property p_rs_hw; restart && !soft_reset
    |=> hardware_control_q == ($past(hardware_control_q) & 8'hDF); endproperty
  a_rs_hw: assert property (p_rs_hw) else $error("bad restart value");
  property p_rs_wd; restart && !soft_reset
    |=> watchdog_control_q == (($past(watchdog_control_q) & 8'h98) | 8'h04); endproperty
  a_rs_wd: assert property (p_rs_wd) else $error("bad restart value");
  property p_dec; 1 |=> failsafe_input_enable == !$past(hardware_control_q[7])
    && boost_enable == $past(hardware_control_q[1]); endproperty
  a_dec: assert property (p_dec) else $error("bad decode");
  property p_force; hardware_control_q[5] |=> fail_outputs; endproperty
  a_force: assert property (p_force) else $error("force ignored");
  property p_res;
    1 |=> watchdog_period_reserved == (&$past(watchdog_control_q[2:0])); endproperty
  a_res: assert property (p_res) else $error("bad reserved flag");
endmodule
bind sbc_ctrl sbc_ctrl_properties u_props (.clock, .rst, .soft_reset, .restart, .frame_valid,
  .frame_data, .read_data, .spi_fail_set, .hardware_control_q, .watchdog_control_q,
  .failsafe_input_enable, .fail_outputs, .boost_enable, .watchdog_period_reserved);

// *** sbc_host_model.sv ***
// host side: one 16-bit frame per call, checksum bit set on watchdog writes
// assumes read data is registered one cycle after the strobe
`timescale 1ns/1ps
module sbc_host_model (
  input  wire         clock,
  input  wire  [7:0]  read_data,
  output logic        frame_valid,
  output logic [15:0] frame_data
);
  initial begin
    frame_valid = 1'b0;
    frame_data = 16'h0000;
  end
  task xfer(input logic [6:0] a, input logic w, bad, input logic [7:0] d,
            output logic [7:0] q);
    if (w && a == 7'h03) d[7] = ^d[6:0] ^ bad;
    @(posedge clock); #1;
    frame_valid = 1'b1;
    frame_data = {d, w, a};
    @(posedge clock); #1;
    frame_valid = 1'b0;
    // released bus shows the inverse, not a stale frame
    frame_data = ~frame_data;
    q = read_data;
  endtask
endmodule

// *** sbc_ctrl_bench.sv ***
// self-checking bench for the control bank
// assumes the host model and bound checker are compiled alongside
`timescale 1ns/1ps
module sbc_ctrl_bench;
  logic        clock = 0, rst = 1, sr = 0, rs = 0, stp = 0, scw = 0, wk = 0;
  logic        h6 = 0, h4 = 0, hpl = 0;
  logic        cfg = 0, ll = 0, fev = 0, wdf = 0, bwk = 0;
  wire         sfo, bpwm, fvo, wwm, wrst;
  int          n_wrst = 0;
  logic [2:0]  hpv = 0;
  logic [7:0]  q;
  wire  [15:0] fd;
  wire  [7:0]  rd, hw, wd;
  wire  [31:0] pc;
  wire         fv, sfs, fie, fo, ben, blv, wa, pres;
  int          mismatches = 0, n_checks = 0, n_fail = 0, f0;
  int          ms[8] = '{10, 20, 50, 100, 200, 500, 1000, 0};
  always #5 clock = ~clock;
  always @(posedge clock) if (sfs === 1'b1) n_fail++;
  always @(posedge clock) if (wrst === 1'b1) n_wrst++;
  sbc_host_model u_host (.clock(clock), .read_data(rd), .frame_valid(fv), .frame_data(fd));
  sbc_ctrl i_dut (.clock(clock), .rst(rst), .soft_reset(sr), .restart(rs), .frame_valid(fv),
    .frame_data(fd), .read_data(rd), .spi_fail_set(sfs), .stop_mode(stp),
    .stop_cmd_written(scw), .wake_pin(wk), .cfg_pin(cfg), .large_load(ll),
    .failure_event(fev), .wd_fail_event(wdf), .hw_wd_stm_off_set(h6),
    .hw_wd_bus_wake_set(h4), .hw_period_load(hpl), .hw_period_value(hpv),
    .hardware_control_q(hw), .watchdog_control_q(wd), .failsafe_input_enable(fie),
    .second_fail_output_mode(sfo), .fail_outputs(fo), .buck_pwm(bpwm), .boost_enable(ben),
    .boost_low_voltage(blv), .failsafe_vcc_off(fvo), .watchdog_active(wa),
    .watchdog_window_mode(wwm), .watchdog_reset(wrst), .watchdog_period_cycles(pc),
    .watchdog_period_reserved(pres), .bus_wake(bwk));
  task chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_reset;
    u_host.xfer(7'h02, 0, 0, 0, q); chk(q, 8'h00);
    u_host.xfer(7'h03, 0, 0, 0, q); chk(q, 8'h14);
    u_host.xfer(7'h00, 0, 0, 0, q); chk(q, 8'h00);
    $display("reset values done");
  endtask
  task t_write;
    u_host.xfer(7'h02, 1, 0, 8'hA5, q);
    u_host.xfer(7'h02, 0, 0, 0, q); chk(q, 8'hA5);
    chk(fie, 0);
    chk(fo, 1);
    chk(ben, 0);
    chk(blv, 1);
    f0 = n_fail;
    u_host.xfer(7'h03, 1, 1, 8'h05, q);
    chk(n_fail - f0, 1);
    u_host.xfer(7'h03, 0, 0, 0, q); chk(q, 8'h14);
    $display("write and checksum done");
  endtask
  task t_period;
    for (int i = 0; i < 8; i++) begin
      u_host.xfer(7'h03, 1, 0, {5'h00, i[2:0]}, q);
      tick(2);
      chk(pc, ms[i] * 100000);
      chk(pres, i == 7);
    end
    $display("period decode done");
  endtask
  task t_restart;
    u_host.xfer(7'h02, 1, 0, 8'hFF, q);
    u_host.xfer(7'h03, 1, 0, 8'h7F, q);
    rs = 1; tick(1); rs = 0;
    chk(hw, 8'hDF);
    chk(wd, 8'h9C);
    sr = 1; tick(1); sr = 0;
    chk(hw, 8'h00);
    chk(wd, 8'h14);
    $display("restart done");
  endtask
  task t_stop;
    u_host.xfer(7'h03, 1, 0, 8'h00, q);
    h6 = 1; h4 = 1; hpl = 1; hpv = 3'h2; tick(1);
    h6 = 0; h4 = 0; hpl = 0;
    chk(wd, 8'h52);
    stp = 1; wk = 1; tick(3);
    chk(wa, 0);
    scw = 1; tick(1); scw = 0; stp = 0; wk = 0; tick(3);
    chk(wa, 1);
    $display("stop mode done");
  endtask
  task wd_fail;
    wdf = 1; tick(1); wdf = 0; tick(2);
  endtask
  task t_fail;
    cfg = 1;
    u_host.xfer(7'h02, 1, 0, 8'h80, q);
    u_host.xfer(7'h03, 1, 0, 8'h08, q);
    tick(2);
    chk(sfo, 1);
    fev = 1; tick(2); chk(fo, 1);
    fev = 0; tick(2); chk(fo, 0);
    f0 = n_wrst;
    wd_fail; chk(fo, 0);
    wd_fail; chk(fo, 1);
    wd_fail; wd_fail;
    chk(n_wrst - f0, 3);
    rs = 1; tick(1); rs = 0; tick(2);
    chk(fvo, 1);
    sr = 1; tick(1); sr = 0; cfg = 0;
    u_host.xfer(7'h03, 1, 0, 8'h70, q);
    stp = 1; tick(3);
    chk(wa, 0);
    chk(wwm, 1);
    bwk = 1; tick(1); bwk = 0; tick(2);
    chk(wa, 1);
    chk(wwm, 0);
    stp = 0; tick(2);
    $display("failure and bus wake done");
  endtask
  task t_buck;
    u_host.xfer(7'h02, 1, 0, 8'h10, q);
    stp = 1; wk = 1; tick(4);
    chk(bpwm, 1);
    wk = 0; tick(100);
    chk(bpwm, 1);
    tick(10000);
    chk(bpwm, 0);
    wk = 1; tick(4);
    chk(bpwm, 1);
    u_host.xfer(7'h02, 1, 0, 8'h08, q);
    wk = 0; tick(4);
    chk(bpwm, 1);
    scw = 1; tick(1); scw = 0; tick(10005);
    chk(bpwm, 0);
    ll = 1; tick(3);
    chk(bpwm, 1);
    ll = 0; stp = 0; tick(2);
    $display("buck mode done");
  endtask
  initial begin
    #500000;
    mismatches++;
    test_done;
  end
  initial begin
    tick(2);
    rst = 0;
    t_reset;
    t_write;
    t_period;
    t_restart;
    t_stop;
    t_fail;
    t_buck;
    test_done;
  end
endmodule
